// [logic/pmbto_pkg.sv]
// Package: constants and types for the turn-off timing and fault summary registers
`default_nettype none

package pmbto_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_TOMAX_ACT  = 8'h63;
	localparam logic [7:0] CMD_TOFF_DLY   = 8'h64;
	localparam logic [7:0] CMD_TURNOFF_FALL_TIME  = 8'h65;
	localparam logic [7:0] CMD_STAT_BYTE  = 8'h78;
	localparam logic [7:0] CMD_STAT_WORD  = 8'h79;

	// ----------------------------------------------------------------
	// Field layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] resp;
		logic [2:0] retry;
		logic [2:0] dly;
	} pmbto_act_t;

	typedef struct packed {
		logic [4:0]  expo;
		logic [10:0] mant;
	} pmbto_lin11_t;

	localparam logic [1:0] RESP_IGNORE   = 2'h0;
	localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
	localparam logic [2:0] RETRY_NONE    = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam logic [2:0] DLYT_NONE     = 3'h0;
	localparam logic [4:0] EXPO_MS       = 5'h00;
	localparam int         DLY_FREE_BITS  = 4;
	localparam int         FALL_FREE_BITS = 5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  ACT_RESET  = 8'h80;
	localparam logic [15:0] DLY_RESET  = 16'h0000;
	localparam logic [15:0] FALL_RESET = 16'h0005;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int SB_BUSY = 7;
	localparam int SB_OFF = 6;
	localparam int SB_VOUT_OV = 5;
	localparam int SB_IOUT_PK = 4;
	localparam int SB_TEMP = 2;
	localparam int SB_CML = 1;
	localparam int SB_OTHER = 0;
	localparam int SW_VOUT = 7;
	localparam int SW_IOUT = 6;
	localparam int SW_INPUT = 5;
	localparam int SW_MFR = 4;
	localparam int SW_PGOOD_N = 3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          MS_NS         = 1000000;
	localparam int          CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
	localparam logic [10:0] HICCUP_MS     = 11'h3E8;
	localparam int          NVM_BUSY_CYC  = 16;

	// ----------------------------------------------------------------
	// Fault events and sequencer states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic vout_ov;
		logic vout_uv;
		logic iout_pk;
		logic iout_other;
		logic temp;
		logic pec_fail;
		logic bad_cmd;
		logic vin_ov;
		logic vin_off;
		logic ocp_avg;
		logic mfr;
		logic tonmax;
	} pmbto_evt_t;

	typedef enum logic [2:0] {
		ST_OFF    = 3'h0,
		ST_RUN    = 3'h1,
		ST_TDLY   = 3'h3,
		ST_TFALL  = 3'h2,
		ST_LATCH  = 3'h6,
		ST_HICCUP = 3'h7
	} pmbto_state_t;

endpackage

`default_nettype wire

// [logic/pmbto_ms_tick.sv]
// Millisecond tick divider with restart
`default_nettype none

module pmbto_ms_tick #(
	parameter int CYC_PER_MS = pmbto_pkg::CYC_PER_MS
) (
	// Clock and reset
	input  wire logic CLK_SYS,
	input  wire logic RESETN,
	// Control
	input  wire logic restart,
	output logic      tick
);

	localparam int W = $clog2(CYC_PER_MS + 1);
	localparam logic [W-1:0] LAST = W'(CYC_PER_MS - 1);

	logic [W-1:0] cnt_q;

	// Restart aligns the first millisecond to the start of an interval
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN || restart || cnt_q == LAST) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	assign tick = (cnt_q == LAST) && !restart;

endmodule

`default_nettype wire

// [logic/pmbto_regs.sv]
// Turn-off timing, start-up timeout response and fault summary registers
`default_nettype none

module pmbto_regs #(
	parameter int CYC_PER_MS = pmbto_pkg::CYC_PER_MS,
	parameter int NVM_CYC    = pmbto_pkg::NVM_BUSY_CYC
) (
	// Clock and reset
	input  wire logic                 CLK_SYS,
	input  wire logic                 RESETN,
	// Command access
	input  wire logic [7:0]           REG_CMD,
	input  wire logic                 REG_WR,
	input  wire logic [15:0]          REG_WDATA,
	input  wire logic                 REG_RD,
	output logic [15:0]               REG_RDATA,
	output logic                      REG_RVALID,
	input  wire logic                 CLEAR_FAULTS,
	input  wire logic                 STORE_ALL,
	// Nonvolatile memory
	input  wire logic                 NVM_BUSY_IN,
	output logic                      NVM_WR,
	output logic [39:0]               NVM_WDATA,
	// Fault events and levels
	input  wire pmbto_pkg::pmbto_evt_t FAULT_EVT,
	input  wire logic                 SHUTDOWN_FAULT,
	input  wire logic                 PGOOD_IN,
	input  wire logic                 TONMAX_ALERT_MASK,
	// Power stage control
	input  wire logic                 ON_CMD,
	output logic                      OUT_ENABLE,
	output logic                      RAMP_DOWN,
	output logic [7:0]                STATUS_VOUT,
	output logic                      HOST_ALERT_OUT_N
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pmbto_pkg::pmbto_act_t   act_q;
	pmbto_pkg::pmbto_lin11_t dly_q;
	pmbto_pkg::pmbto_lin11_t fall_q;
	pmbto_pkg::pmbto_evt_t   flt_q;
	pmbto_pkg::pmbto_state_t st_q;
	pmbto_pkg::pmbto_state_t st_d;
	pmbto_pkg::pmbto_act_t   wr_act;
	pmbto_pkg::pmbto_lin11_t wr_lin;
	logic                    ivd_q;
	logic                    ivd_set;
	logic                    alert_n_q;
	logic [10:0]             ms_cnt_q;
	logic                    tick;
	logic                    st_chg;
	logic [7:0]              stat_byte;
	logic [7:0]              stat_hi;
	logic [15:0]             rdata_q;
	logic                    rvalid_q;
	logic [$clog2(NVM_CYC+1)-1:0] nvm_cnt_q;
	logic                    nvm_wr_q;
	logic [39:0]             nvm_data_q;

	// ----------------------------------------------------------------
	// Write checks
	// ----------------------------------------------------------------
	function automatic logic act_ok(input pmbto_pkg::pmbto_act_t a);
		act_ok = (a.resp == pmbto_pkg::RESP_IGNORE || a.resp == pmbto_pkg::RESP_SHUTDOWN) &&
			(a.retry == pmbto_pkg::RETRY_NONE || a.retry == pmbto_pkg::RETRY_FOREVER) &&
			a.dly == pmbto_pkg::DLYT_NONE;
	endfunction

	// Mantissa must fit the given number of low bits; exponent fixed at ms
	function automatic logic lin_ok(input pmbto_pkg::pmbto_lin11_t v, input int bits);
		lin_ok = v.expo == pmbto_pkg::EXPO_MS && (v.mant >> bits) == 11'h000;
	endfunction

	assign wr_act = pmbto_pkg::pmbto_act_t'(REG_WDATA[7:0]);
	assign wr_lin = pmbto_pkg::pmbto_lin11_t'(REG_WDATA);

	always_comb begin
		ivd_set = 1'b0;
		if (REG_WR) begin
			case (REG_CMD)
				pmbto_pkg::CMD_TOMAX_ACT: ivd_set = !act_ok(wr_act);
				pmbto_pkg::CMD_TOFF_DLY: ivd_set = !lin_ok(wr_lin, pmbto_pkg::DLY_FREE_BITS);
				pmbto_pkg::CMD_TURNOFF_FALL_TIME: ivd_set = !lin_ok(wr_lin, pmbto_pkg::FALL_FREE_BITS) ||
					wr_lin.mant == 11'h000;
				default: ivd_set = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Settings registers
	// ----------------------------------------------------------------
	// Rejected data leaves the stored setting untouched; exponent stays zero
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			act_q <= pmbto_pkg::ACT_RESET;
			dly_q <= pmbto_pkg::DLY_RESET;
			fall_q <= pmbto_pkg::FALL_RESET;
		end else if (REG_WR && !ivd_set) begin
			case (REG_CMD)
				pmbto_pkg::CMD_TOMAX_ACT: act_q <= wr_act;
				pmbto_pkg::CMD_TOFF_DLY: dly_q.mant <= wr_lin.mant;
				pmbto_pkg::CMD_TURNOFF_FALL_TIME: fall_q.mant <= wr_lin.mant;
				default: act_q <= act_q;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Store to nonvolatile memory
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			nvm_cnt_q <= '0;
			nvm_wr_q <= 1'b0;
			nvm_data_q <= '0;
		end else begin
			nvm_wr_q <= 1'b0;
			if (STORE_ALL && nvm_cnt_q == '0) begin
				nvm_cnt_q <= ($clog2(NVM_CYC+1))'(NVM_CYC);
				nvm_wr_q <= 1'b1;
				nvm_data_q <= {act_q, dly_q, fall_q};
			end else if (nvm_cnt_q != '0) begin
				nvm_cnt_q <= nvm_cnt_q - 1'b1;
			end
		end
	end

	assign NVM_WR = nvm_wr_q;
	assign NVM_WDATA = nvm_data_q;

	// ----------------------------------------------------------------
	// Sticky faults
	// ----------------------------------------------------------------
	// A new event in the clearing cycle wins, so no fault is lost
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			flt_q <= '0;
			ivd_q <= 1'b0;
		end else begin
			flt_q <= (CLEAR_FAULTS ? '0 : flt_q) | FAULT_EVT;
			ivd_q <= (CLEAR_FAULTS ? 1'b0 : ivd_q) | ivd_set;
		end
	end

	// ----------------------------------------------------------------
	// Status summaries
	// ----------------------------------------------------------------
	always_comb begin
		stat_byte = 8'h00;
		stat_byte[pmbto_pkg::SB_BUSY] = NVM_BUSY_IN || nvm_cnt_q != '0;
		stat_byte[pmbto_pkg::SB_OFF] = !OUT_ENABLE;
		stat_byte[pmbto_pkg::SB_VOUT_OV] = flt_q.vout_ov;
		stat_byte[pmbto_pkg::SB_IOUT_PK] = flt_q.iout_pk;
		stat_byte[pmbto_pkg::SB_TEMP] = flt_q.temp;
		stat_byte[pmbto_pkg::SB_CML] = flt_q.pec_fail || flt_q.bad_cmd || ivd_q;
		stat_byte[pmbto_pkg::SB_OTHER] = flt_q.vin_ov || flt_q.vin_off || flt_q.ocp_avg ||
			flt_q.iout_other || flt_q.mfr || flt_q.vout_uv;
		stat_hi = 8'h00;
		stat_hi[pmbto_pkg::SW_VOUT] = flt_q.tonmax || flt_q.vout_ov || flt_q.vout_uv;
		stat_hi[pmbto_pkg::SW_IOUT] = flt_q.iout_pk || flt_q.ocp_avg || flt_q.iout_other;
		stat_hi[pmbto_pkg::SW_INPUT] = flt_q.vin_ov || flt_q.vin_off;
		stat_hi[pmbto_pkg::SW_MFR] = flt_q.mfr;
		stat_hi[pmbto_pkg::SW_PGOOD_N] = !PGOOD_IN;
	end

	// Output-voltage status bits owned here; the rest are filled elsewhere
	assign STATUS_VOUT = {5'h00, flt_q.tonmax, 2'h0};

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= REG_RD;
			if (REG_RD) begin
				case (REG_CMD)
					pmbto_pkg::CMD_TOMAX_ACT: rdata_q <= {8'h00, act_q};
					pmbto_pkg::CMD_TOFF_DLY: rdata_q <= dly_q;
					pmbto_pkg::CMD_TURNOFF_FALL_TIME: rdata_q <= fall_q;
					pmbto_pkg::CMD_STAT_BYTE: rdata_q <= {8'h00, stat_byte};
					pmbto_pkg::CMD_STAT_WORD: rdata_q <= {stat_hi, stat_byte};
					default: rdata_q <= 16'h0000;
				endcase
			end
		end
	end

	assign REG_RDATA = rdata_q;
	assign REG_RVALID = rvalid_q;

	// ----------------------------------------------------------------
	// Alert
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			alert_n_q <= 1'b1;
		end else begin
			alert_n_q <= !((flt_q.tonmax && !TONMAX_ALERT_MASK) || ivd_q ||
				(|(flt_q & ~pmbto_pkg::pmbto_evt_t'(1'b1))));
		end
	end

	assign HOST_ALERT_OUT_N = alert_n_q;

	// ----------------------------------------------------------------
	// Millisecond timing
	// ----------------------------------------------------------------
	pmbto_ms_tick #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_tick (
		.CLK_SYS(CLK_SYS),
		.RESETN (RESETN),
		.restart(st_chg),
		.tick   (tick)
	);

	assign st_chg = st_d != st_q;

	// Interval count restarts on every state change
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN || st_chg) begin
			ms_cnt_q <= 11'h000;
		end else if (tick && ms_cnt_q != 11'h7FF) begin
			ms_cnt_q <= ms_cnt_q + 11'h001;
		end
	end

	// ----------------------------------------------------------------
	// Output sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		case (st_q)
			pmbto_pkg::ST_OFF: begin
				if (ON_CMD) begin
					st_d = pmbto_pkg::ST_RUN;
				end
			end
			pmbto_pkg::ST_RUN, pmbto_pkg::ST_TDLY, pmbto_pkg::ST_TFALL: begin
				if (SHUTDOWN_FAULT) begin
					st_d = pmbto_pkg::ST_LATCH;
				end else if (FAULT_EVT.tonmax && act_q.resp == pmbto_pkg::RESP_SHUTDOWN) begin
					st_d = (act_q.retry == pmbto_pkg::RETRY_FOREVER) ? pmbto_pkg::ST_HICCUP
						: pmbto_pkg::ST_LATCH;
				end else if (st_q == pmbto_pkg::ST_RUN && !ON_CMD) begin
					st_d = pmbto_pkg::ST_TDLY;
				end else if (st_q == pmbto_pkg::ST_TDLY && ms_cnt_q >= dly_q.mant) begin
					st_d = pmbto_pkg::ST_TFALL;
				end else if (st_q == pmbto_pkg::ST_TFALL && ms_cnt_q >= fall_q.mant) begin
					st_d = pmbto_pkg::ST_OFF;
				end
			end
			pmbto_pkg::ST_LATCH: begin
				if (CLEAR_FAULTS) begin
					st_d = pmbto_pkg::ST_OFF;
				end
			end
			pmbto_pkg::ST_HICCUP: begin
				if (SHUTDOWN_FAULT) begin
					st_d = pmbto_pkg::ST_LATCH;
				end else if (!ON_CMD) begin
					st_d = pmbto_pkg::ST_OFF;
				end else if (ms_cnt_q >= pmbto_pkg::HICCUP_MS) begin
					st_d = pmbto_pkg::ST_RUN;
				end
			end
			default: st_d = pmbto_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			st_q <= pmbto_pkg::ST_OFF;
		end else begin
			st_q <= st_d;
		end
	end

	// Fall phase keeps switching while the target ramps to zero
	assign OUT_ENABLE = st_q == pmbto_pkg::ST_RUN || st_q == pmbto_pkg::ST_TDLY ||
		st_q == pmbto_pkg::ST_TFALL;
	assign RAMP_DOWN = st_q == pmbto_pkg::ST_TFALL;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_tonmax_summary: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		FAULT_EVT.tonmax |=> stat_hi[pmbto_pkg::SW_VOUT] && STATUS_VOUT[2])
		else $error("timeout fault not summarised");
	chk_tonmax_alert: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		FAULT_EVT.tonmax && !TONMAX_ALERT_MASK ##1 !TONMAX_ALERT_MASK |=> !HOST_ALERT_OUT_N)
		else $error("timeout fault gave no alert");
	chk_fault_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		flt_q.tonmax && !CLEAR_FAULTS |=> flt_q.tonmax)
		else $error("fault bit dropped without clear");
	chk_act_reset: assert property (@(posedge CLK_SYS)
		!RESETN |=> act_q == pmbto_pkg::ACT_RESET)
		else $error("response register reset wrong");
	chk_ignore_runs: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		st_q == pmbto_pkg::ST_RUN && ON_CMD && !SHUTDOWN_FAULT && act_q.resp == pmbto_pkg::RESP_IGNORE
		|=> st_q == pmbto_pkg::ST_RUN)
		else $error("ignore response stopped output");
	chk_latch_stays: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		st_q == pmbto_pkg::ST_LATCH && !CLEAR_FAULTS |=> st_q == pmbto_pkg::ST_LATCH && !OUT_ENABLE)
		else $error("latch-off left without clear");
	chk_hiccup_restart: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		st_q == pmbto_pkg::ST_HICCUP && ON_CMD && !SHUTDOWN_FAULT && ms_cnt_q == pmbto_pkg::HICCUP_MS
		|=> st_q == pmbto_pkg::ST_RUN)
		else $error("hiccup did not restart");
	chk_bad_act_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		REG_WR && REG_CMD == pmbto_pkg::CMD_TOMAX_ACT && REG_WDATA[7:6] == 2'h1 && !CLEAR_FAULTS
		|=> ivd_q && $stable(act_q))
		else $error("unsupported response accepted");
	chk_fall_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		REG_WR && REG_CMD == pmbto_pkg::CMD_TURNOFF_FALL_TIME && REG_WDATA == 16'h0000
		|=> ivd_q && fall_q.mant != 11'h000)
		else $error("zero fall time accepted");
	chk_busy_bit: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		NVM_BUSY_IN |-> stat_byte[pmbto_pkg::SB_BUSY])
		else $error("busy not shown");
	chk_unsup_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		REG_RVALID && $past(REG_CMD) == pmbto_pkg::CMD_STAT_WORD |-> REG_RDATA[10:8] == 3'h0 && !REG_RDATA[3])
		else $error("unsupported status bit set");
	chk_pgood_bit: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		REG_RD && REG_CMD == pmbto_pkg::CMD_STAT_WORD |=> REG_RDATA[11] == !$past(PGOOD_IN))
		else $error("power-good flag wrong");

endmodule

`default_nettype wire

// [verification/pmbto_host.sv]
// Host model: drives the command strobes and collects read answers
`default_nettype none

module pmbto_host (
	// Clock
	input  wire logic        clk,
	// Command access
	output logic [7:0]       reg_cmd,
	output logic             reg_wr,
	output logic [15:0]      reg_wdata,
	output logic             reg_rd,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_cmd = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
		reg_rd = 1'b0;
	end

	// ----------------------------------------------------------------
	// Transfers, launched on the falling edge
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		reg_cmd = c;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// Released data is scrambled so no stale value looks valid
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
		@(negedge clk);
		reg_cmd = c;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_cmd = ~c;
		d = reg_rdata;
		v = reg_rvalid;
	endtask
endmodule

`default_nettype wire

// [verification/pmbto_regs_bench.sv]
// Self-checking bench for the turn-off timing and fault summary registers
`default_nettype none

module pmbto_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int MS = 4;
	logic                  CLK_SYS = 1'b0;
	logic                  RESETN = 1'b0;
	logic [7:0]            cmd;
	logic [15:0]           wdata;
	logic [15:0]           rdata;
	logic                  wr;
	logic                  rd;
	logic                  rv;
	logic                  clr = 1'b0;
	logic                  sto = 1'b0;
	logic                  nbusy = 1'b0;
	logic                  nwr;
	logic [39:0]           nwd;
	pmbto_pkg::pmbto_evt_t evt = '0;
	logic                  shut = 1'b0;
	logic                  pg = 1'b1;
	logic                  mask = 1'b0;
	logic                  on = 1'b0;
	logic                  oen;
	logic                  ramp;
	logic [7:0]            svout;
	logic                  alert_n;
	int                    bad_count = 0;
	int                    cmp_count = 0;

	always #4 CLK_SYS = ~CLK_SYS;

	pmbto_regs #(.CYC_PER_MS(MS), .NVM_CYC(4)) i_pmbto_regs (
		.CLK_SYS(CLK_SYS), .RESETN(RESETN), .REG_CMD(cmd), .REG_WR(wr), .REG_WDATA(wdata),
		.REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rv), .CLEAR_FAULTS(clr), .STORE_ALL(sto),
		.NVM_BUSY_IN(nbusy), .NVM_WR(nwr), .NVM_WDATA(nwd), .FAULT_EVT(evt),
		.SHUTDOWN_FAULT(shut), .PGOOD_IN(pg), .TONMAX_ALERT_MASK(mask), .ON_CMD(on),
		.OUT_ENABLE(oen), .RAMP_DOWN(ramp), .STATUS_VOUT(svout), .HOST_ALERT_OUT_N(alert_n)
	);

	pmbto_host i_pmbto_host (
		.clk(CLK_SYS), .reg_cmd(cmd), .reg_wr(wr), .reg_wdata(wdata),
		.reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rv)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] d;
		logic        v;
		i_pmbto_host.rd(c, d, v);
		chk({39'h0, v}, 40'h1);
		chk(40'(d), 40'(e));
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge CLK_SYS);
	endtask

	task automatic pulse_evt(input int b);
		@(negedge CLK_SYS);
		evt = pmbto_pkg::pmbto_evt_t'(12'h001 << b);
		@(negedge CLK_SYS);
		evt = '0;
		cyc(2);
	endtask

	task automatic clear;
		@(negedge CLK_SYS);
		clr = 1'b1;
		@(negedge CLK_SYS);
		clr = 1'b0;
		cyc(2);
	endtask

	task automatic report_and_stop;
		$display("counts: %0d compared, %0d wrong", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_refuse;
		logic [7:0]  ct [10] = '{8'h63, 8'h63, 8'h63, 8'h63, 8'h64, 8'h64, 8'h65, 8'h65, 8'h65, 8'h63};
		logic [15:0] dt [10] = '{16'h0040, 16'h00C0, 16'h0088, 16'h0081, 16'h0010, 16'h0800,
			16'h0000, 16'h0020, 16'h0801, 16'h00B0};
		for (int i = 0; i < 10; i++) begin
			i_pmbto_host.wr(ct[i], dt[i]);
			rdchk(ct[i], (ct[i] == 8'h63) ? 16'h0080 : (ct[i] == 8'h64) ? 16'h0000 : 16'h0005);
			rdchk(8'h78, 16'h0042);
			chk({39'h0, alert_n}, 40'h0);
			clear();
			rdchk(8'h78, 16'h0040);
		end
		i_pmbto_host.wr(8'h78, 16'hFFFF);
		rdchk(8'h78, 16'h0040);
		rdchk(8'h00, 16'h0000);
	endtask

	task automatic t_settings;
		i_pmbto_host.wr(8'h64, 16'h000A);
		i_pmbto_host.wr(8'h65, 16'h0014);
		rdchk(8'h64, 16'h000A);
		rdchk(8'h65, 16'h0014);
		i_pmbto_host.wr(8'h64, 16'h0002);
		i_pmbto_host.wr(8'h65, 16'h0001);
		rdchk(8'h78, 16'h0040);
	endtask

	task automatic t_turnoff;
		int n = 0;
		int r = 0;
		on = 1'b1;
		cyc(6);
		chk({39'h0, oen}, 40'h1);
		rdchk(8'h78, 16'h0000);
		on = 1'b0;
		while (n < 40 && oen === 1'b1) begin
			@(negedge CLK_SYS);
			n++;
			if (ramp === 1'b1 && r == 0) r = n;
		end
		chk(40'(n >= 3 * MS - 2 && n <= 3 * MS + 3), 40'h1);
		chk(40'(r >= 2 * MS - 2 && r <= 2 * MS + 3), 40'h1);
		chk(40'(n - r >= MS - 1), 40'h1);
	endtask

	task automatic t_store;
		@(negedge CLK_SYS);
		sto = 1'b1;
		@(negedge CLK_SYS);
		sto = 1'b0;
		chk({39'h0, nwr}, 40'h1);
		chk(nwd, 40'h80_0002_0001);
		rdchk(8'h78, 16'h00C0);
		cyc(8);
		nbusy = 1'b1;
		rdchk(8'h78, 16'h00C0);
		nbusy = 1'b0;
		rdchk(8'h78, 16'h0040);
	endtask

	task automatic t_status;
		logic [15:0] ew [12] = '{16'h8040, 16'h1041, 16'h4041, 16'h2041, 16'h2041, 16'h0042,
			16'h0042, 16'h0044, 16'h4041, 16'h4050, 16'h8041, 16'h8060};
		for (int b = 0; b < 12; b++) begin
			pulse_evt(b);
			cyc(10);
			rdchk(8'h79, ew[b]);
			rdchk(8'h78, 16'(ew[b][7:0]));
			chk({39'h0, alert_n}, 40'h0);
			clear();
			rdchk(8'h79, 16'h0040);
			chk({39'h0, alert_n}, 40'h1);
		end
		pg = 1'b0;
		rdchk(8'h79, 16'h0840);
		pg = 1'b1;
		rdchk(8'h79, 16'h0040);
	endtask

	task automatic t_timeout;
		on = 1'b1;
		cyc(6);
		pulse_evt(0);
		cyc(50);
		chk({39'h0, oen}, 40'h0);
		chk(40'(svout), 40'h04);
		chk({39'h0, alert_n}, 40'h0);
		rdchk(8'h79, 16'h8040);
		mask = 1'b1;
		cyc(3);
		chk({39'h0, alert_n}, 40'h1);
		mask = 1'b0;
		clear();
		cyc(4);
		chk({39'h0, oen}, 40'h1);
		chk(40'(svout), 40'h00);
		i_pmbto_host.wr(8'h63, 16'h0000);
		pulse_evt(0);
		cyc(5);
		chk({39'h0, oen}, 40'h1);
		chk(40'(svout), 40'h04);
		clear();
	endtask

	task automatic t_hiccup;
		int n = 0;
		i_pmbto_host.wr(8'h63, 16'h00B8);
		rdchk(8'h63, 16'h00B8);
		pulse_evt(0);
		chk({39'h0, oen}, 40'h0);
		while (n < 5000 && oen !== 1'b1) begin
			@(negedge CLK_SYS);
			n++;
		end
		chk(40'(n >= 1000 * MS - 4 && n <= 1000 * MS + 10), 40'h1);
		// Command off during the hiccup wait ends the retries at once
		pulse_evt(0);
		chk({39'h0, oen}, 40'h0);
		on = 1'b0;
		cyc(2);
		on = 1'b1;
		cyc(4);
		chk({39'h0, oen}, 40'h1);
		// Another fault during the hiccup wait latches the output off
		pulse_evt(0);
		@(negedge CLK_SYS);
		shut = 1'b1;
		@(negedge CLK_SYS);
		shut = 1'b0;
		cyc(1000 * MS + 20);
		chk({39'h0, oen}, 40'h0);
		clear();
		chk({39'h0, oen}, 40'h1);
		on = 1'b0;
		i_pmbto_host.wr(8'h63, 16'h0080);
		clear();
	endtask

	// Mid-run reset brings back the defaults and drops captured faults
	task automatic t_reset;
		i_pmbto_host.wr(8'h63, 16'h0000);
		i_pmbto_host.wr(8'h65, 16'h0009);
		pulse_evt(11);
		@(negedge CLK_SYS);
		RESETN = 1'b0;
		cyc(4);
		RESETN = 1'b1;
		chk({39'h0, alert_n}, 40'h1);
		rdchk(8'h63, 16'h0080);
		rdchk(8'h65, 16'h0005);
		rdchk(8'h79, 16'h0040);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		cyc(4);
		RESETN = 1'b1;
		rdchk(8'h63, 16'h0080);
		rdchk(8'h64, 16'h0000);
		rdchk(8'h65, 16'h0005);
		rdchk(8'h79, 16'h0040);
		chk({39'h0, alert_n}, 40'h1);
		t_refuse();
		t_settings();
		t_turnoff();
		t_store();
		t_status();
		t_timeout();
		t_hiccup();
		t_reset();
		report_and_stop();
	end

	// Whole run needs about 8700 cycles; the two hiccup-length waits dominate
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		bad_count++;
		report_and_stop();
	end
endmodule

`default_nettype wire
